/* hw/siop_pkg.sv */
package siop_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int PORT_W  = 8;
    localparam int IDENT_W = 2;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the register bus)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFF_IDENT  = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_PORT   = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ST_FLAG_BIT  = 0;
    localparam int ST_LIVE_BIT  = 1;
    localparam int ST_MODE_LSB  = 2;
    localparam int ST_BUSY_BIT  = 4;
    localparam int PR_LATCH_LSB = 0;
    localparam int PR_DIR_LSB   = 8;
    localparam int PR_PINS_LSB  = 16;

    // Control byte layout
    localparam int CB_TARGET_BIT = 5;
    localparam int CB_DIR_BIT    = 4;
    localparam int CB_FMT_HI_BIT = 3;
    localparam int CB_FMT_LO_BIT = 2;
    localparam int CB_MODE_HI    = 1;
    localparam int CB_MODE_LO    = 0;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR   = 8'h00;
    localparam logic [1:0] RST_IDENT = 2'h0;
    localparam logic [1:0] RST_MODE  = 2'h0;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [2:0] ID_BIT    = 3'h1;

    localparam logic [1:0] CMP_ANY_MISS = 2'h0;
    localparam logic [1:0] CMP_ALL_HIT  = 2'h1;
    localparam logic [1:0] CMP_ALL_MISS = 2'h2;
    localparam logic [1:0] CMP_ANY_HIT  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Link states, Gray along idle, control, data
    typedef enum logic [1:0] {
        LNK_IDLE = 2'b00,
        LNK_CTRL = 2'b01,
        LNK_DATA = 2'b11,
        LNK_SKIP = 2'b10
    } siop_link_e;

endpackage : siop_pkg

/* hw/siop_sync.sv */
`timescale 1ns/10ps
module siop_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // Two flops; only the second stage is seen by the rest of the block
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= RST;
            q    <= RST;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : siop_sync

/* hw/siop_top.sv */
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module siop_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Serial link
    input  wire logic        sck,
    input  wire logic        select_low,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe_n,
    // Port pins, three signals per pin
    input  wire logic [7:0]  port_pins_i,
    output logic      [7:0]  port_pins_o,
    output logic      [7:0]  port_pins_oe_n
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Compare condition over a per-bit match vector
    function automatic logic cond_eval(input logic [1:0] mode, input logic [7:0] hit);
        logic res;
        res = 1'b0;
        case (mode)
            siop_pkg::CMP_ANY_MISS: res = ~&hit;
            siop_pkg::CMP_ALL_HIT:  res = &hit;
            siop_pkg::CMP_ALL_MISS: res = ~|hit;
            siop_pkg::CMP_ANY_HIT:  res = |hit;
            default:                res = 1'b0;
        endcase
        return res;
    endfunction : cond_eval

    // New register value from old value, received byte and format bits
    function automatic logic [7:0] apply_write(input logic [1:0] fmt, input logic [7:0] old,
                                               input logic [7:0] din);
        logic [7:0] res;
        res = din;
        if (fmt[1]) begin
            if (fmt[0]) begin
                res = old | din;
            end else begin
                res = old & ~din;
            end
        end
        return res;
    endfunction : apply_write

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [10:0] sync_q;
    logic        sck_s;
    logic        sel_s;
    logic        mosi_s;
    logic [7:0]  pins_s;

    // Serial clock sampled like any other pin; link rate stays well below aclk
    siop_sync #(
        .W   (11),
        .RST (11'h200)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({sck, select_low, mosi, port_pins_i}),
        .q       (sync_q)
    );

    assign sck_s  = sync_q[10];
    assign sel_s  = sync_q[9];
    assign mosi_s = sync_q[8];
    assign pins_s = sync_q[7:0];

    // ------------------------------------------------------------------
    // Port registers and compare
    // ------------------------------------------------------------------
    logic [7:0] latch_bits;
    logic [7:0] dir_bits;
    logic [1:0] ident_cfg;
    logic [1:0] cmp_mode;
    logic       cmp_flag;
    logic [7:0] hit_vec;
    logic       cond_now;
    logic [7:0] latch_view;

    // Outputs always match, inputs compare live level with latch
    assign hit_vec    = dir_bits | ~(pins_s ^ latch_bits);
    assign cond_now   = cond_eval(cmp_mode, hit_vec);
    assign latch_view = (dir_bits & latch_bits) | (~dir_bits & pins_s);

    // ------------------------------------------------------------------
    // Link edge detection
    // ------------------------------------------------------------------
    logic sck_d;
    logic sel_d;
    logic cpol;
    logic sel_fall;
    logic sel_rise;
    logic sck_edge;
    logic lead_edge;
    logic trail_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_d <= 1'b0;
            sel_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            sel_d <= sel_s;
        end
    end

    assign sel_fall   = sel_d & ~sel_s;
    assign sel_rise   = ~sel_d & sel_s;
    assign sck_edge   = (sck_s != sck_d) & ~sel_s;
    // Leading edge leaves the idle level and shifts out, trailing edge captures
    assign lead_edge  = sck_edge & (sck_s != cpol);
    assign trail_edge = sck_edge & (sck_s == cpol);

    // ------------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------------
    siop_pkg::siop_link_e lnk_state;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [2:0] bit_cnt;
    logic       tgt_dir;
    logic       wr_op;
    logic [1:0] fmt;
    logic       wr_done;
    logic [7:0] rx_byte;
    logic [7:0] tgt_view;

    assign rx_byte  = {rx_sh[6:0], mosi_s};
    assign tgt_view = tgt_dir ? dir_bits : latch_view;

    // Framing, shifting and register updates; select release wins over all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lnk_state      <= siop_pkg::LNK_IDLE;
            rx_sh          <= 8'h00;
            tx_sh          <= 8'h00;
            bit_cnt        <= 3'h0;
            cpol           <= 1'b0;
            cmp_flag       <= 1'b0;
            cmp_mode       <= siop_pkg::RST_MODE;
            tgt_dir        <= 1'b0;
            wr_op          <= 1'b0;
            fmt            <= 2'h0;
            wr_done        <= 1'b0;
            miso           <= 1'b0;
            miso_oe_n      <= 1'b1;
            latch_bits     <= siop_pkg::RST_LATCH;
            dir_bits       <= siop_pkg::RST_DIR;
            port_pins_o    <= siop_pkg::RST_LATCH;
            port_pins_oe_n <= ~siop_pkg::RST_DIR;
        end else if (sel_rise) begin
            lnk_state <= siop_pkg::LNK_IDLE;
            bit_cnt   <= 3'h0;
            rx_sh     <= 8'h00;
            wr_done   <= 1'b0;
            miso_oe_n <= 1'b1;
        end else if (sel_fall) begin
            cpol      <= sck_s;
            cmp_flag  <= cond_now;
            tx_sh     <= {cond_now, 7'h00};
            bit_cnt   <= 3'h0;
            wr_done   <= 1'b0;
            lnk_state <= siop_pkg::LNK_CTRL;
            miso      <= 1'b0;
            miso_oe_n <= 1'b0;
        end else begin
            case (lnk_state)
                siop_pkg::LNK_IDLE: begin
                    miso_oe_n <= 1'b1;
                end
                siop_pkg::LNK_SKIP: begin
                    miso_oe_n <= 1'b1;
                end
                siop_pkg::LNK_CTRL, siop_pkg::LNK_DATA: begin
                    if (lead_edge) begin
                        miso  <= tx_sh[7];
                        tx_sh <= {tx_sh[6:0], 1'b0};
                    end
                    if (trail_edge) begin
                        rx_sh   <= rx_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (lnk_state == siop_pkg::LNK_CTRL && bit_cnt == siop_pkg::ID_BIT
                            && rx_byte[1:0] != ident_cfg) begin
                            lnk_state <= siop_pkg::LNK_SKIP;
                            miso_oe_n <= 1'b1;
                        end else if (bit_cnt == siop_pkg::LAST_BIT) begin
                            if (lnk_state == siop_pkg::LNK_CTRL) begin
                                tgt_dir   <= rx_byte[siop_pkg::CB_TARGET_BIT];
                                wr_op     <= rx_byte[siop_pkg::CB_DIR_BIT];
                                fmt       <= {rx_byte[siop_pkg::CB_FMT_HI_BIT],
                                              rx_byte[siop_pkg::CB_FMT_LO_BIT]};
                                cmp_mode  <= {rx_byte[siop_pkg::CB_MODE_HI],
                                              rx_byte[siop_pkg::CB_MODE_LO]};
                                // Old content goes out next, for reads and writes alike
                                tx_sh     <= rx_byte[siop_pkg::CB_TARGET_BIT] ?
                                             dir_bits : latch_view;
                                lnk_state <= siop_pkg::LNK_DATA;
                            end else if (wr_op) begin
                                // Commit at the eighth captured bit; pins follow now
                                wr_done   <= 1'b1;
                                miso_oe_n <= 1'b1;
                                if (tgt_dir) begin
                                    dir_bits       <= apply_write(fmt, dir_bits, rx_byte);
                                    port_pins_oe_n <= ~apply_write(fmt, dir_bits, rx_byte);
                                end else begin
                                    latch_bits     <= apply_write(fmt, latch_bits, rx_byte);
                                    port_pins_o    <= apply_write(fmt, latch_bits, rx_byte);
                                end
                            end else begin
                                tx_sh <= tgt_view;
                            end
                        end
                    end
                    // Once a write is done MISO stays released to frame end
                    if (wr_done) begin
                        miso_oe_n <= 1'b1;
                    end
                end
                default: begin
                    lnk_state <= siop_pkg::LNK_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic       aw_held;
    logic       w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Address and data taken in either order; response once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= siop_pkg::RESP_OKAY;
            ident_cfg     <= siop_pkg::RST_IDENT;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == siop_pkg::OFF_IDENT) begin
                    s_axi_bresp <= siop_pkg::RESP_OKAY;
                    if (w_strb[0]) begin
                        ident_cfg <= w_data[1:0];
                    end
                end else if (aw_addr == siop_pkg::OFF_STATUS ||
                             aw_addr == siop_pkg::OFF_PORT) begin
                    s_axi_bresp <= siop_pkg::RESP_OKAY; // Read-only, write ignored
                end else begin
                    s_axi_bresp <= siop_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic        rd_hit;

    // Read mux; unmapped words read zero with an error
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            siop_pkg::OFF_IDENT: begin
                rd_word[1:0] = ident_cfg;
            end
            siop_pkg::OFF_STATUS: begin
                rd_word[siop_pkg::ST_FLAG_BIT]                    = cmp_flag;
                rd_word[siop_pkg::ST_LIVE_BIT]                    = cond_now;
                rd_word[siop_pkg::ST_MODE_LSB +: 2]               = cmp_mode;
                rd_word[siop_pkg::ST_BUSY_BIT]                    = ~sel_s;
            end
            siop_pkg::OFF_PORT: begin
                rd_word[siop_pkg::PR_LATCH_LSB +: 8] = latch_bits;
                rd_word[siop_pkg::PR_DIR_LSB +: 8]   = dir_bits;
                rd_word[siop_pkg::PR_PINS_LSB +: 8]  = pins_s;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // One read at a time; address taken and answered on the same edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= siop_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? siop_pkg::RESP_OKAY : siop_pkg::RESP_SLVERR;
            end
        end
    end

endmodule : siop_top

/* tb/siop_chk.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module siop_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Link and pins
    input wire logic        select_low,
    input wire logic        miso_oe_n,
    input wire logic [7:0]  port_pins_o,
    input wire logic [7:0]  port_pins_oe_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Pins and serial output come out of reset quiet
    AST_DIR_RST: assert property ($rose(aresetn) |->
        port_pins_oe_n == 8'hFF && miso_oe_n)
        else $error("pins not inputs after reset");
    // Sync delay is two cycles and release one more, so five idle samples leave margin
    AST_MISO_IDLE: assert property (select_low [*5] |-> miso_oe_n)
        else $error("miso driven while deselected");
    AST_PIN_CHG: assert property (!$stable({port_pins_o, port_pins_oe_n}) |->
        !$past(select_low, 4))
        else $error("pins changed outside a frame");
    // Commit and release of the serial output share one edge
    AST_WR_REL: assert property (!$stable({port_pins_o, port_pins_oe_n}) |->
        miso_oe_n)
        else $error("miso still driven after commit");
    AST_AR_ANS: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=>
        s_axi_arready && s_axi_rvalid)
        else $error("read not answered");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_AW_ONE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready too long");

    // Main scenarios
    CV_COMMIT: cover property (!$stable(port_pins_o));
    CV_SELECT: cover property ($fell(miso_oe_n));
    CV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule : siop_chk

bind siop_top siop_chk siop_chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .select_low, .miso_oe_n, .port_pins_o, .port_pins_oe_n);

/* tb/siop_spi_master.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Serial master model
// ----------------------------------------
module siop_spi_master (
    // Clock
    input wire logic aclk,
    // Link
    input wire logic miso,
    input wire logic miso_oe_n,
    output logic     sck,
    output logic     select_low,
    output logic     mosi
);
    logic fill = 1'b0;

    // Idle link at time zero
    initial begin
        sck = 1'b0;
        select_low = 1'b1;
        mosi = 1'b0;
    end

    // One frame of nb bits; released miso reads as a toggling pattern
    task automatic xfer(input logic pol, input int nb, input logic [31:0] tx,
                        output logic [31:0] rx);
        rx = 32'h0000_0000;
        sck <= pol;
        repeat (6) @(posedge aclk);
        select_low <= 1'b0;
        repeat (6) @(posedge aclk);
        for (int i = 0; i < nb; i++) begin
            mosi <= tx[31-i];
            sck <= ~pol;
            repeat (4) @(posedge aclk);
            fill = ~fill;
            rx[31-i] = miso_oe_n ? fill : miso;
            sck <= pol;
            repeat (4) @(posedge aclk);
        end
        select_low <= 1'b1;
        mosi <= ~mosi;
        repeat (6) @(posedge aclk);
    endtask : xfer
endmodule : siop_spi_master

/* tb/tb_siop_top.sv */
`timescale 1ns/10ps
module tb_siop_top;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, sck, select_low, mosi, miso, miso_oe_n;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rx, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]  port_pins_i, port_pins_o, port_pins_oe_n;
    int          bad_count, n_compared, cyc;
    localparam logic [1:0] IDV = 2'h2; // Arbitrary identity value
    localparam logic [7:0] PV [3] = '{8'hF5, 8'h0A, 8'h5A};
    localparam logic [7:0] DV [2] = '{8'h0F, 8'h00};

    siop_top siop_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck, .select_low, .mosi, .miso,
        .miso_oe_n, .port_pins_i, .port_pins_o, .port_pins_oe_n);
    siop_spi_master siop_spi_master_i (.aclk, .miso, .miso_oe_n, .sck, .select_low, .mosi);

    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp

    // Latch 0A; output pins always count as a hit
    function automatic logic flag(input logic [1:0] m, input logic [7:0] p, input logic [7:0] d);
        logic [7:0] hit;
        hit = ~(p ^ 8'h0A) | d;
        case (m)
            2'h0: flag = ~&hit;
            2'h1: flag = &hit;
            2'h2: flag = ~|hit;
            default: flag = |hit;
        endcase
    endfunction : flag

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            s_axi_awvalid <= ~aw;
            s_axi_wvalid <= ~w;
        end while (!(aw && w));
        // One idle edge lets the response wait once before it is taken
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        // Late ready makes the read data wait one edge
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    // Clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Hang guard, well above the expected run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        port_pins_i = 8'h50;
        {bad_count, n_compared} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        cmp(port_pins_oe_n, 8'hFF);
        axi_rd(4'hC, rd, rs);
        cmp(rs, siop_pkg::RESP_SLVERR);
        axi_wr(siop_pkg::OFF_IDENT, {30'h0, IDV}, rs);
        cmp(rs, siop_pkg::RESP_OKAY);
        siop_spi_master_i.xfer(1'b0, 16, {IDV, 6'h30, 8'h0F, 16'h0}, rx);
        cmp(rx[23:16], 8'h00);
        cmp(port_pins_oe_n, 8'hF0);
        siop_spi_master_i.xfer(1'b1, 16, {IDV, 6'h14, 8'hAA, 16'h0}, rx);
        cmp(port_pins_o, 8'hAA);
        siop_spi_master_i.xfer(1'b0, 16, {IDV, 6'h1C, 8'hF0, 16'h0}, rx);
        cmp(rx[23:16], 8'h5A);
        cmp(port_pins_o, 8'hFA);
        siop_spi_master_i.xfer(1'b0, 16, {IDV, 6'h18, 8'hF0, 16'h0}, rx);
        cmp(port_pins_o, 8'h0A);
        // Foreign identity, then a byte cut short
        siop_spi_master_i.xfer(1'b0, 16, {~IDV, 6'h10, 8'hFF, 16'h0}, rx);
        siop_spi_master_i.xfer(1'b0, 12, {IDV, 6'h10, 8'hFF, 16'h0}, rx);
        cmp(port_pins_o, 8'h0A);
        siop_spi_master_i.xfer(1'b0, 32, {IDV, 6'h0C, 24'h0}, rx);
        cmp(rx[23:0], 24'h5A5A5A);
        axi_rd(siop_pkg::OFF_PORT, rd, rs);
        cmp(rd[15:0], 16'h0F0A);
        // Each frame reveals the flag of the previous frame's mode
        foreach (DV[d]) begin
            siop_spi_master_i.xfer(1'b0, 16, {IDV, 6'h30, DV[d], 16'h0}, rx);
            foreach (PV[p]) begin
                port_pins_i <= PV[p];
                for (int m = 0; m < 5; m++) begin
                    siop_spi_master_i.xfer(1'b0, 16, {IDV, 4'h0, 2'(m), 24'h0}, rx);
                    if (m > 0)
                        cmp(rx[31:24], {flag(2'(m - 1), PV[p], DV[d]), 7'h00});
                end
            end
        end
        // Last frame latched the mode 3 flag and set mode 0, live condition now uses mode 0, link idle
        axi_rd(siop_pkg::OFF_STATUS, rd, rs);
        cmp(rd[4:0], {3'h0, flag(2'h0, 8'h5A, 8'h00), flag(2'h3, 8'h5A, 8'h00)});
        end_of_test();
    end
endmodule : tb_siop_top
